/* File: i2c_port_control_one_tb_top.sv */
// Self-checking bench for the two-wire port control block.
// Assumes ipc_pkg, ipc_ctrl and ipc_bus_model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", nm, (e), (g)); end end
module i2c_port_control_one_tb_top;
  import ipc_pkg::*;
  // ****************
  // Bench
  // ****************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic scl, sda;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ipc_pad_s gpio_pad, pad_q;
  int n_fail = 0;
  int n_checks = 0;
  wire [1:0] sclp = {pad_q.scl_oe, pad_q.scl_o};
  ipc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .sda_i(sda), .gpio_pad(gpio_pad), .pad_q(pad_q), .irq(irq));
  ipc_bus_model m (.pclk(pclk), .pad(pad_q), .scl(scl), .sda(sda));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // One APB transfer, held until pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 40) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, e}, rd)
  endtask : rdc
  // Reset values, control bits, unmapped access, pin hand-over
  task automatic t_regs;
    rdc("ctrl1", ADDR_CTRL1, CTRL1_RST);
    rdc("aux", ADDR_AUX, AUX_RST);
    rdc("irqs", ADDR_IRQS, {3'h0, IRQ_RST});
    apb(1'b0, 8'h1C, 8'h00);
    `CHK("slverr", 1'b1, er)
    wr(ADDR_CTRL1, 8'hDB);
    rdc("ctrl1", ADDR_CTRL1, 8'hDB);
    wr(ADDR_CTRL1, 8'h24);
    wt(3);
    `CHK("resv", 2'b00, {pad_q.scl_oe, pad_q.sda_oe})
    wr(ADDR_CTRL1, 8'h00);
    wt(3);
    `CHK("gpio", gpio_pad, pad_q)
    gpio_pad <= 4'b1010;
    wt(3);
    `CHK("gpio2", 4'b1010, pad_q)
  endtask : t_regs
  // Stretch in each slave code, none in master, firmware pin drive
  task automatic t_modes;
    logic [3:0] sl[4] = '{MODE_S7, MODE_S7I, MODE_S10, MODE_S10I};
    foreach (sl[i]) begin
      wr(ADDR_CTRL1, {4'h2, sl[i]});
      wt(3);
      `CHK("hold", 2'b10, sclp)
      wr(ADDR_CTRL1, {4'h3, sl[i]});
      wt(3);
      `CHK("free", 1'b0, pad_q.scl_oe)
    end
    wr(ADDR_CTRL1, {4'h2, MODE_MST});
    wt(3);
    `CHK("mst", 1'b0, pad_q.scl_oe)
    wr(ADDR_AUX, 8'h08);
    wr(ADDR_CTRL1, {4'h2, MODE_FW});
    wt(3);
    `CHK("fw", 3'b100, {sclp, pad_q.sda_oe})
    wr(ADDR_AUX, AUX_RST);
  endtask : t_modes
  // Hardware master sends a byte; a second write collides
  task automatic t_mtx;
    wr(ADDR_IRQM, 8'h01);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_AUX, 8'h0D);
    wr(ADDR_CTRL1, {4'h2, MODE_MST});
    wr(ADDR_BUF, 8'hA5);
    wr(ADDR_BUF, 8'h5A);
    rdc("write_collision_flag", ADDR_CTRL1, 8'hA8);
    `CHK("irq", 1'b1, irq)
    for (int k = 0; k < 60; k++) begin
      apb(1'b0, ADDR_STAT, 8'h00);
      if (rd[ST_BUSY] !== 1'b1) break;
    end
    `CHK("mtx", 8'hA5, m.cap[8:1])
    wr(ADDR_IRQS, 8'h01);
    wr(ADDR_CTRL1, {4'h2, MODE_MST});
    wt(2);
    `CHK("irqc", 1'b0, irq)
    wr(ADDR_AUX, AUX_RST);
  endtask : t_mtx
  // Slave receive, masked event, overflow keeping the first byte
  task automatic t_srx;
    wr(ADDR_IRQS, 8'h1F);
    wr(ADDR_CTRL1, {4'h3, MODE_S7});
    m.cond(1'b0);
    m.bits({8'h3C, 1'b1}, 9);
    m.cond(1'b1);
    apb(1'b0, ADDR_STAT, 8'h00);
    `CHK("rxf", 1'b1, rd[ST_RXF])
    rdc("irqs", ADDR_IRQS, 8'h04);
    `CHK("mask", 1'b0, irq)
    m.cond(1'b0);
    m.bits({8'hC3, 1'b1}, 9);
    m.cond(1'b1);
    rdc("ovf", ADDR_CTRL1, 8'h76);
    rdc("keep", ADDR_BUF, 8'h3C);
  endtask : t_srx
  // Start and stop events in the interrupt-enabled slave codes
  task automatic t_ss;
    logic [3:0] cd[2] = '{MODE_S7I, MODE_S10I};
    foreach (cd[i]) begin
      wr(ADDR_CTRL1, {4'h3, cd[i]});
      wr(ADDR_IRQS, 8'h1F);
      m.cond(1'b0);
      m.cond(1'b1);
      rdc("ss", ADDR_IRQS, 8'h18);
    end
  endtask : t_ss
  // Slave transmit; a buffer write in mid-byte collides
  task automatic t_stx;
    wr(ADDR_AUX, 8'h0D);
    wr(ADDR_CTRL1, {4'h3, MODE_S7});
    m.cond(1'b0);
    wr(ADDR_BUF, 8'h96);
    m.bits(9'h1FF, 3);
    `CHK("stx", 3'b100, m.cap[2:0])
    wr(ADDR_BUF, 8'h11);
    m.bits(9'h1FF, 6);
    m.cond(1'b1);
    rdc("write_collision_flag", ADDR_CTRL1, 8'hB6);
  endtask : t_stx
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gpio_pad = 4'b0101; // General I/O drives both lines low
    wt(12);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_mtx();
    t_srx();
    t_ss();
    t_stx();
    print_verdict();
  end
  // Cuts a hung run short
  initial begin
    wt(20000);
    n_fail++;
    print_verdict();
  end
endmodule : i2c_port_control_one_tb_top

/* File: ipc_bus_model.sv */
// Far-side two-wire party: pull-ups, wired-and lines, clock and data.
// Assumes the block's registered pad drive and the bench's pclk.
`timescale 1ns/1ps
module ipc_bus_model (
  input wire logic pclk,
  input wire ipc_pkg::ipc_pad_s pad,
  output logic scl,
  output logic sda
);
  import ipc_pkg::*;
  // ****************
  // Line model
  // ****************
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  logic [8:0] cap = '0;
  // Released lines float to the pull-up level
  assign scl = !(pad.scl_oe && !pad.scl_o) && !scl_low;
  assign sda = !(pad.sda_oe && !pad.sda_o) && !sda_low;
  // Data taken on each rising clock, first bit ends up on top
  always @(posedge scl) cap <= {cap[7:0], sda};
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // Lets the clock go and waits out any stretching
  task automatic rel;
    int k;
    scl_low <= 1'b0;
    wt(1);
    for (k = 0; k < 300 && !scl; k++) wt(1);
    wt(8);
  endtask : rel
  // Start with clock high, or stop from clock low
  task automatic cond(input logic stop);
    sda_low <= 1'b1;
    wt(8);
    if (stop) begin
      rel();
      sda_low <= 1'b0;
    end else begin
      scl_low <= 1'b1;
    end
    wt(8);
  endtask : cond
  // Clocks the low n of nine bits, top first; a one releases data
  task automatic bits(input logic [8:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      wt(2);
      sda_low <= !d[i];
      wt(6);
      rel();
      scl_low <= 1'b1;
    end
  endtask : bits
endmodule : ipc_bus_model

/* File: ipc_ctrl.sv */
// Two-wire port control block: control register, shift buffer, master
// and slave shift engines, pin ownership and interrupt logic.
// Assumes an APB master on pclk and pads resolved outside the block.
// Function
// - A master-mode buffer write that cannot start sets the collision flag.
// - A slave-transmit buffer write during shifting sets the collision flag.
// - The collision flag means nothing while receiving.
// - A byte completing while the buffer is unread sets the overflow flag.
// - Setting the enable bit gives both pins to the port.
// - Clearing the enable bit hands both pins back to general I/O.
// - In slave mode the release bit frees the clock, clear stretches it.
// - In master mode the release bit has no effect.
// - Codes 1110 and 0110 pick 7-bit slave, with and without start/stop irq.
// - Codes 1111 and 0111 pick 10-bit slave, with and without irq.
// - Code 1011 picks firmware master with the slave logic idle.
// - Code 1000 picks hardware master, clock is fosc/(4*(reload+1)).
// - Any other mode code leaves the two-wire logic inactive.
`timescale 1ns/1ps
module ipc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire ipc_pkg::ipc_pad_s gpio_pad,
  output ipc_pkg::ipc_pad_s pad_q,
  output logic irq
);
  import ipc_pkg::*;

  // ******************************************************
  // Mode decode
  // ******************************************************
  function automatic logic is_slave(input logic [3:0] m);
    is_slave = (m == MODE_S7) || (m == MODE_S10) ||
               (m == MODE_S7I) || (m == MODE_S10I);
  endfunction : is_slave

  logic [7:0] ctrl1_q;
  logic [7:0] buf_q;
  logic [7:0] baud_q;
  logic [7:0] aux_q;
  logic [4:0] irqs_q;
  logic [4:0] irqm_q;
  logic rx_full_q;
  logic [3:0] mode;
  logic en;
  logic m_slv;
  logic m_mst;
  logic m_fw;
  logic m_ssirq;
  assign mode = ctrl1_q[3:0];
  assign en = ctrl1_q[CTL_EN];
  assign m_slv = en && is_slave(mode);
  assign m_mst = en && (mode == MODE_MST);
  assign m_fw = en && (mode == MODE_FW);
  assign m_ssirq = m_slv && mode[3];

  // ******************************************************
  // Pin synchronisers and bus condition detect
  // ******************************************************
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic scl_p_q;
  logic sda_p_q;
  logic bus_busy_q;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_s = scl_sy_q[1];
  assign sda_s = sda_sy_q[1];
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_ev = scl_s && scl_p_q && !sda_s && sda_p_q;
  assign stop_ev = scl_s && scl_p_q && sda_s && !sda_p_q;

  // Two-stage sync then one delay for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_q <= 2'b11;
      sda_sy_q <= 2'b11;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Bus busy from start until stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_busy_q <= 1'b0;
    end else if (start_ev) begin
      bus_busy_q <= 1'b1;
    end else if (stop_ev || !en) begin
      bus_busy_q <= 1'b0;
    end
  end

  // ******************************************************
  // APB access decode
  // ******************************************************
  logic acc;
  logic wr;
  logic rd_buf;
  logic wr_buf;
  logic map_hit;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd_buf = acc && !pwrite && (paddr == ADDR_BUF);
  assign wr_buf = wr && (paddr == ADDR_BUF);
  assign map_hit = (paddr == ADDR_CTRL1) || (paddr == ADDR_BUF) ||
                   (paddr == ADDR_BAUD) || (paddr == ADDR_AUX) ||
                   (paddr == ADDR_STAT) || (paddr == ADDR_IRQS) ||
                   (paddr == ADDR_IRQM);

  // ******************************************************
  // Hardware master engine
  // ******************************************************
  ipc_mst_e ms_q;
  logic [8:0] div_q;
  logic [3:0] ms_cnt_q;
  logic [7:0] ms_sr_q;
  logic ms_tx_q;
  logic tick;
  logic ms_can_go;
  logic ms_write_collision_flag;
  logic ms_go;
  logic ms_done;
  assign tick = (div_q == {baud_q, 1'b1});
  assign ms_can_go = m_mst && (ms_q == MS_IDLE) && !bus_busy_q;
  assign ms_write_collision_flag = wr_buf && m_mst && aux_q[AUX_TX] && !ms_can_go;
  assign ms_go = ms_can_go && ((wr_buf && aux_q[AUX_TX]) ||
                 (wr && paddr == ADDR_AUX && pwdata[AUX_GO]));
  assign ms_done = (ms_q == MS_HIGH) && tick && (ms_cnt_q == ACK_BIT);

  // Half-period divider, held while a slave stretches the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 9'h000;
    end else if (ms_q == MS_IDLE || tick) begin
      div_q <= 9'h000;
    end else if (ms_q == MS_LOW || scl_s) begin
      div_q <= div_q + 9'h001;
    end
  end

  // Master byte sequencer, eight data bits plus ack slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q <= MS_IDLE;
      ms_cnt_q <= 4'h0;
      ms_sr_q <= 8'h00;
      ms_tx_q <= 1'b0;
    end else if (!m_mst) begin
      ms_q <= MS_IDLE;
    end else begin
      case (ms_q)
        MS_IDLE: begin
          if (ms_go) begin
            ms_q <= MS_LOW;
            ms_cnt_q <= 4'h0;
            ms_tx_q <= aux_q[AUX_TX];
            ms_sr_q <= aux_q[AUX_TX] ? pwdata[7:0] : 8'h00;
          end
        end
        MS_LOW: begin
          if (tick) begin
            ms_q <= MS_HIGH;
          end
        end
        MS_HIGH: begin
          if (tick) begin
            if (ms_cnt_q != ACK_BIT) begin
              ms_sr_q <= {ms_sr_q[6:0], ms_tx_q ? 1'b0 : sda_s};
            end
            ms_cnt_q <= ms_cnt_q + 4'h1;
            ms_q <= (ms_cnt_q == ACK_BIT) ? MS_IDLE : MS_LOW;
          end
        end
        default: begin
          ms_q <= MS_IDLE;
        end
      endcase
    end
  end

  // ******************************************************
  // Slave engine, idle outside slave modes
  // ******************************************************
  logic [3:0] sl_cnt_q;
  logic [7:0] sl_sr_q;
  logic sl_busy_q;
  logic sl_tx;
  logic sl_write_collision_flag;
  logic sl_rx_done;
  assign sl_tx = m_slv && aux_q[AUX_TX];
  assign sl_write_collision_flag = wr_buf && sl_tx && sl_busy_q;
  assign sl_rx_done = m_slv && !aux_q[AUX_TX] && scl_rise &&
                      (sl_cnt_q == LAST_BIT);

  // Shift in on clock rise, shift out on clock fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_cnt_q <= 4'h0;
      sl_sr_q <= 8'h00;
      sl_busy_q <= 1'b0;
    end else if (!m_slv) begin
      sl_cnt_q <= 4'h0;
      sl_busy_q <= 1'b0;
    end else if (start_ev) begin
      sl_cnt_q <= 4'h0;
    end else if (sl_tx) begin
      if (wr_buf && !sl_busy_q) begin
        sl_sr_q <= pwdata[7:0];
        sl_busy_q <= 1'b1;
        sl_cnt_q <= 4'h0;
      end else if (sl_busy_q && scl_fall) begin
        sl_sr_q <= {sl_sr_q[6:0], 1'b1};
        sl_cnt_q <= sl_cnt_q + 4'h1;
        sl_busy_q <= (sl_cnt_q != LAST_BIT);
      end
    end else if (scl_rise) begin
      sl_sr_q <= {sl_sr_q[6:0], sda_s};
      sl_cnt_q <= (sl_cnt_q == LAST_BIT) ? 4'h0 : sl_cnt_q + 4'h1;
    end
  end

  // ******************************************************
  // Receive buffer and overflow
  // ******************************************************
  logic rx_done;
  logic [7:0] rx_byte;
  logic ovf_ev;
  assign rx_done = sl_rx_done || (ms_done && !ms_tx_q);
  assign rx_byte = sl_rx_done ? {sl_sr_q[6:0], sda_s} : ms_sr_q;
  assign ovf_ev = rx_done && rx_full_q;

  // New byte only lands in an empty buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (rx_done && !rx_full_q) begin
      buf_q <= rx_byte;
      rx_full_q <= 1'b1;
    end else if (rd_buf || !en) begin
      rx_full_q <= 1'b0;
    end
  end

  // ******************************************************
  // Software registers
  // ******************************************************
  // Control register, hardware flag set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= CTRL1_RST;
    end else begin
      if (wr && paddr == ADDR_CTRL1) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (ms_write_collision_flag || sl_write_collision_flag) begin
        ctrl1_q[CTL_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (ovf_ev) begin
        ctrl1_q[CTL_OVF] <= 1'b1;
      end
    end
  end

  // Baud reload and auxiliary control, go bit self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_q <= BAUD_RST;
      aux_q <= AUX_RST;
    end else begin
      if (wr && paddr == ADDR_BAUD) begin
        baud_q <= pwdata[7:0];
      end
      if (wr && paddr == ADDR_AUX) begin
        aux_q <= pwdata[7:0] & ~(8'h01 << AUX_GO);
      end
    end
  end

  // Sticky interrupt status, write one clears, set wins
  logic [4:0] irq_ev;
  assign irq_ev = {m_ssirq && stop_ev, m_ssirq && start_ev, rx_done,
                   ovf_ev, ms_write_collision_flag || sl_write_collision_flag};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqs_q <= IRQ_RST;
      irqm_q <= IRQ_RST;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_IRQS) begin
        irqs_q <= (irqs_q & ~pwdata[4:0]) | irq_ev;
      end else begin
        irqs_q <= irqs_q | irq_ev;
      end
      if (wr && paddr == ADDR_IRQM) begin
        irqm_q <= pwdata[4:0];
      end
      irq <= |(irqs_q & irqm_q);
    end
  end

  // APB answer, one wait state, registered data
  logic [7:0] stat;
  assign stat = {3'b000, sda_s, scl_s, bus_busy_q,
                 (ms_q != MS_IDLE) || sl_busy_q, rx_full_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !map_hit;
      case (paddr)
        ADDR_CTRL1: prdata <= {24'h000000, ctrl1_q};
        ADDR_BUF: prdata <= {24'h000000, buf_q};
        ADDR_BAUD: prdata <= {24'h000000, baud_q};
        ADDR_AUX: prdata <= {24'h000000, aux_q};
        ADDR_STAT: prdata <= {24'h000000, stat};
        ADDR_IRQS: prdata <= {27'h0000000, irqs_q};
        ADDR_IRQM: prdata <= {27'h0000000, irqm_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ******************************************************
  // Pad ownership
  // ******************************************************
  logic scl_low;
  logic sda_low;
  assign scl_low = (m_mst && ms_q == MS_LOW) ||
                   (m_slv && !ctrl1_q[CTL_CKP]) ||
                   (m_fw && !aux_q[AUX_FSCL]);
  assign sda_low = (m_mst && ms_q != MS_IDLE && ms_tx_q &&
                    ms_cnt_q != ACK_BIT && !ms_sr_q[7]) ||
                   (sl_tx && sl_busy_q && !sl_sr_q[7]) ||
                   (m_fw && !aux_q[AUX_FSDA]);

  // Port drives low only, else general I/O owns the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '0;
    end else if (en) begin
      pad_q <= '{1'b0, scl_low, 1'b0, sda_low};
    end else begin
      pad_q <= gpio_pad;
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  sequence s_buf_wr;
    psel && penable && pready && pwrite && paddr == ADDR_BUF;
  endsequence
  property p_write_collision_flag_mst;
    @(posedge pclk) disable iff (!presetn)
      (m_mst && aux_q[AUX_TX] && ms_q != MS_IDLE) ##0 s_buf_wr
      |=> ctrl1_q[CTL_WRITE_COLLISION_FLAG] && irqs_q[IRQ_WRITE_COLLISION_FLAG];
  endproperty
  a_write_collision_flag_mst: assert property (p_write_collision_flag_mst) else $error("no master write_collision_flag");
  property p_write_collision_flag_slv;
    @(posedge pclk) disable iff (!presetn)
      (sl_tx && sl_busy_q) ##0 s_buf_wr |=> ctrl1_q[CTL_WRITE_COLLISION_FLAG];
  endproperty
  a_write_collision_flag_slv: assert property (p_write_collision_flag_slv) else $error("no slave write_collision_flag");
  property p_ovf_keep;
    @(posedge pclk) disable iff (!presetn)
      rx_done && rx_full_q |=> ctrl1_q[CTL_OVF] && buf_q == $past(buf_q);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
  property p_gpio;
    @(posedge pclk) disable iff (!presetn)
      !en |=> pad_q == $past(gpio_pad);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pins not returned");
  property p_stretch;
    @(posedge pclk) disable iff (!presetn)
      m_slv && !ctrl1_q[CTL_CKP] |=> pad_q.scl_oe && !pad_q.scl_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");
  property p_ckp_mst;
    @(posedge pclk) disable iff (!presetn)
      m_mst && ms_q == MS_IDLE |=> !pad_q.scl_oe;
  endproperty
  a_ckp_mst: assert property (p_ckp_mst) else $error("ckp acts in master");
  property p_fw_idle;
    @(posedge pclk) disable iff (!presetn)
      m_fw |=> !sl_busy_q && sl_cnt_q == 4'h0;
  endproperty
  a_fw_idle: assert property (p_fw_idle) else $error("slave not idle");
  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
      en && !m_mst && !m_fw && !m_slv |=> !pad_q.scl_oe && !pad_q.sda_oe;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code drives");
  property p_half;
    @(posedge pclk) disable iff (!presetn)
      ms_q == MS_LOW && $changed(ms_q) && baud_q == 8'h00
      |-> ##1 ms_q == MS_LOW ##1 ms_q == MS_HIGH;
  endproperty
  a_half: assert property (p_half) else $error("bad half period");
endmodule : ipc_ctrl

/* File: ipc_pkg.sv */
// Package for the two-wire port control block: register map, field
// positions, reset values, mode codes, engine states and pad carrier.
// Assumes a 32-bit APB bus and byte-wide registers in the low bits.
package ipc_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_BUF = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_AUX = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQS = 8'h14;
  localparam logic [7:0] ADDR_IRQM = 8'h18;
  // Control register 1 fields
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_EN = 5;
  localparam int CTL_CKP = 4;
  // Auxiliary control fields
  localparam int AUX_TX = 0;
  localparam int AUX_GO = 1;
  localparam int AUX_FSCL = 2;
  localparam int AUX_FSDA = 3;
  // Status fields
  localparam int ST_RXF = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_BUSBUSY = 2;
  localparam int ST_SCL = 3;
  localparam int ST_SDA = 4;
  // Interrupt status and mask fields
  localparam int IRQ_WRITE_COLLISION_FLAG = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_BYTE = 2;
  localparam int IRQ_START = 3;
  localparam int IRQ_STOP = 4;
  localparam int IRQ_W = 5;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h0C;
  localparam logic [4:0] IRQ_RST = 5'h00;
  // Mode select codes
  localparam logic [3:0] MODE_S10I = 4'hF;
  localparam logic [3:0] MODE_S7I = 4'hE;
  localparam logic [3:0] MODE_FW = 4'hB;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_S10 = 4'h7;
  localparam logic [3:0] MODE_S7 = 4'h6;
  // Last data bit index and ack slot index
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // Hardware master engine states
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_LOW = 3'b010,
    MS_HIGH = 3'b100
  } ipc_mst_e;
  // Open-drain pad pair, output value and enable for each line
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ipc_pad_s;
endpackage : ipc_pkg
